// >>> design/lvdc_capture.sv
// ddr lvds sample capture: pairs rising/falling words, fifo, output word stream
// assumes: ddr_source_clock, lanes and sync/align pins are sampled on clock after
// two flops; the source clock is much slower than clock (oversampled edges)
//
// Notes on behaviour
// - one word is taken on each edge of the source clock, two per source cycle.
// - the rising-edge word fills the first slot and the falling-edge word the second.
// - without bus reversal lane 11 is the msb and lane 0 the lsb.
// - sync is sampled on the source clock rising edge and resets the fifo pointers.
// - align is sampled on the converter clock rising edge and resets the dividers.
// - words are offset binary: all zeros is full-scale current, all ones is none.
// - while transmit_gate is low input is ignored and the word path carries zeros, so current_output_r drives full scale.
`timescale 1ns/1ps
module lvdc_capture #(
   parameter int DATA_W = lvdc_pkg::DATA_W,
   parameter int AW = lvdc_pkg::FIFO_AW,
   parameter int DIV_W = lvdc_pkg::DIV_W
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic ddr_source_clock,
   input wire logic [DATA_W-1:0] lane_data,
   input wire logic fifo_sync_input,
   input wire logic converter_sample_clock,
   input wire logic divider_align_input,
   input wire logic transmit_gate,
   input wire logic bus_reverse,
   input wire logic [DATA_W-1:0] lane_enable,
   output logic [DATA_W-1:0] sample_word_r,
   output logic sample_valid_r,
   output logic [DATA_W-1:0] current_output_r,
   output logic [DIV_W-1:0] divider_count_r,
   output logic fifo_overflow_r
);
   // ==========================================================
   // input synchronisers
   logic [DATA_W-1:0] data_s1_r, data_s2_r;
   logic [5:0] ctl_s1_r, ctl_s2_r;
   logic dclk_d_r, cclk_d_r;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         data_s1_r <= '0;
         data_s2_r <= '0;
         ctl_s1_r <= '0;
         ctl_s2_r <= '0;
      end else begin
         data_s1_r <= lane_data;
         data_s2_r <= data_s1_r;
         ctl_s1_r <= {ddr_source_clock, fifo_sync_input, converter_sample_clock,
                      divider_align_input, transmit_gate, bus_reverse};
         ctl_s2_r <= ctl_s1_r;
      end
   end

   logic dclk_s, sync_s, cclk_s, align_s, gate_s, rev_s;
   assign {dclk_s, sync_s, cclk_s, align_s, gate_s, rev_s} = ctl_s2_r;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dclk_d_r <= 1'b0;
         cclk_d_r <= 1'b0;
      end else begin
         dclk_d_r <= dclk_s;
         cclk_d_r <= cclk_s;
      end
   end

   logic dclk_rise, dclk_fall, cclk_rise;
   assign dclk_rise = dclk_s & ~dclk_d_r;
   assign dclk_fall = ~dclk_s & dclk_d_r;
   assign cclk_rise = cclk_s & ~cclk_d_r;

   // ==========================================================
   // word capture
   function automatic logic [DATA_W-1:0] lvdc_order(input logic [DATA_W-1:0] w,
                                                    input logic rev);
      logic [DATA_W-1:0] o;
      o = w;
      if (rev) begin
         for (int i = 0; i < DATA_W; i++) begin
            o[i] = w[DATA_W-1-i];
         end
      end
      return o;
   endfunction : lvdc_order

   logic [DATA_W-1:0] word_in;
   // disabled word bits (lane_enable is applied after bus reversal) and a closed gate both force zeros
   assign word_in = gate_s ? (lvdc_order(data_s2_r, rev_s) & lane_enable)
                           : lvdc_pkg::GATED_WORD;

   logic [DATA_W-1:0] first_slot_r;
   logic have_first_r;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         first_slot_r <= '0;
         have_first_r <= 1'b0;
      end else if (dclk_rise) begin
         first_slot_r <= word_in;
         have_first_r <= 1'b1;
      end else if (dclk_fall) begin
         have_first_r <= 1'b0;
      end
   end

   // ==========================================================
   // fifo of sample pairs
   logic [AW:0] wr_ptr_r, rd_ptr_r;
   logic wr_en, fifo_full, fifo_empty, sync_hit;
   assign sync_hit = dclk_rise & sync_s;
   assign fifo_full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                      (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
   assign fifo_empty = wr_ptr_r == rd_ptr_r;
   // pair is only written once its falling word arrives
   assign wr_en = dclk_fall & have_first_r & ~fifo_full & ~sync_hit;

   logic [2*DATA_W-1:0] rd_pair;
   lvdc_pair_mem #(.WIDTH(2*DATA_W), .AW(AW)) i_lvdc_pair_mem (
      .clock(clock),
      .wr_en(wr_en),
      .wr_addr(wr_ptr_r[AW-1:0]),
      .wr_data({first_slot_r, word_in}),
      .rd_addr(rd_ptr_r[AW-1:0]),
      .rd_data(rd_pair)
   );

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wr_ptr_r <= '0;
         fifo_overflow_r <= 1'b0;
      end else if (sync_hit) begin
         wr_ptr_r <= '0;
         fifo_overflow_r <= 1'b0;
      end else begin
         if (wr_en) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (dclk_fall & have_first_r & fifo_full) begin
            fifo_overflow_r <= 1'b1;
         end
      end
   end

   // ==========================================================
   // read side: one pair per two converter clock rises
   typedef enum logic [1:0] {LVDC_IDLE, LVDC_WAIT, LVDC_FIRST, LVDC_SECOND} lvdc_state_t;
   lvdc_state_t rd_state_r;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rd_ptr_r <= '0;
         rd_state_r <= LVDC_IDLE;
         sample_word_r <= lvdc_pkg::WORD_ZERO_CURRENT;
         sample_valid_r <= 1'b0;
      end else if (sync_hit) begin
         rd_ptr_r <= '0;
         rd_state_r <= LVDC_IDLE;
         sample_valid_r <= 1'b0;
      end else begin
         sample_valid_r <= 1'b0;
         unique case (rd_state_r)
            LVDC_IDLE: begin
               if (cclk_rise && !fifo_empty) begin
                  rd_state_r <= LVDC_WAIT;
               end
            end
            LVDC_WAIT: begin
               rd_state_r <= LVDC_FIRST; // registered memory read lands here
            end
            LVDC_FIRST: begin
               sample_word_r <= gate_s ? rd_pair[2*DATA_W-1:DATA_W] : lvdc_pkg::GATED_WORD;
               sample_valid_r <= 1'b1;
               rd_state_r <= LVDC_SECOND;
            end
            LVDC_SECOND: begin
               if (cclk_rise) begin
                  sample_word_r <= gate_s ? rd_pair[DATA_W-1:0] : lvdc_pkg::GATED_WORD;
                  sample_valid_r <= 1'b1;
                  rd_ptr_r <= rd_ptr_r + 1'b1;
                  rd_state_r <= LVDC_IDLE;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // output current code and converter-clock dividers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         current_output_r <= '0;
      end else if (sample_valid_r) begin
         // offset binary: code zero drives full scale
         current_output_r <= ~sample_word_r;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         divider_count_r <= lvdc_pkg::DIV_RESET;
      end else if (cclk_rise) begin
         if (align_s) begin
            divider_count_r <= lvdc_pkg::DIV_RESET;
         end else begin
            divider_count_r <= divider_count_r + 1'b1;
         end
      end
   end
endmodule : lvdc_capture

// >>> design/lvdc_pair_mem.sv
// small sample-pair memory for the input fifo
// assumes: single clock, one write and one read port, registered read data
`timescale 1ns/1ps
module lvdc_pair_mem #(
   parameter int WIDTH = 24,
   parameter int AW = 3
) (
   input wire logic clock,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // no reset on the array or the read register; the reader only uses read data after its wait state
   always_ff @(posedge clock) begin
      rd_data <= mem[rd_addr];
   end
endmodule : lvdc_pair_mem

// >>> inc/lvdc_pkg.sv
// constants for the ddr lvds sample capture front end
// assumes: one system clock; link pins arrive asynchronously and are resynchronised
package lvdc_pkg;
   localparam int DATA_W = 12;
   localparam int LANE_W = 12;
   // all-zeros word is full-scale current in offset binary
   localparam logic [11:0] WORD_FULL_SCALE = 12'h000;
   localparam logic [11:0] WORD_ZERO_CURRENT = 12'hfff;
   localparam logic [11:0] GATED_WORD = 12'h000;
   localparam logic [11:0] LANE_ENA_RESET = 12'hfff;
   localparam int FIFO_AW = 3;
   localparam int DIV_W = 4;
   localparam logic [3:0] DIV_RESET = 4'h0;
endpackage : lvdc_pkg

// >>> verif/lvdc_capture_asserts.sv
// port assertions for the ddr sample capture block
// assumes: bound into lvdc_capture, one clock domain
`timescale 1ns/1ps
module lvdc_capture_asserts #(
   parameter int DATA_W = 12,
   parameter int DIV_W = 4
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic transmit_gate,
   input wire logic bus_reverse,
   input wire logic [DATA_W-1:0] lane_enable,
   input wire logic divider_align_input,
   input wire logic [DATA_W-1:0] sample_word_r,
   input wire logic sample_valid_r,
   input wire logic [DATA_W-1:0] current_output_r,
   input wire logic [DIV_W-1:0] divider_count_r
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // ==========
   // properties
   property p_inv; sample_valid_r |=> current_output_r == ~sample_word_r; endproperty
   a_inv: assert property (p_inv) else $error("current code not inverse of word");
   property p_rel; $fell(rst) |-> current_output_r == ~sample_word_r; endproperty
   a_rel: assert property (p_rel) else $error("reset code pair inconsistent");
   property p_hold; $changed(sample_word_r) |-> sample_valid_r; endproperty
   a_hold: assert property (p_hold) else $error("word changed without strobe");
   property p_pulse; sample_valid_r |=> !sample_valid_r; endproperty
   a_pulse: assert property (p_pulse) else $error("strobe longer than one cycle");
   property p_gate; (!transmit_gate)[*6] ##0 sample_valid_r |-> sample_word_r == '0; endproperty
   a_gate: assert property (p_gate) else $error("gated word not zero");
   property p_lane;
      sample_valid_r && !bus_reverse |-> (sample_word_r & ~lane_enable) == '0;
   endproperty
   a_lane: assert property (p_lane) else $error("disabled lane leaked");
   property p_align;
      // align pin seen three samples back is exactly what the divider step used
      $changed(divider_count_r) && $past(divider_align_input, 3)
         |-> divider_count_r == '0;
   endproperty
   a_align: assert property (p_align) else $error("divider not reset by align");
   property p_count;
      $changed(divider_count_r) && !$past(divider_align_input, 3)
         |-> divider_count_r == DIV_W'($past(divider_count_r) + 1);
   endproperty
   a_count: assert property (p_count) else $error("divider step wrong");
   c_valid: cover property (sample_valid_r);
   c_gate: cover property (!transmit_gate && sample_valid_r);
   c_div: cover property ($changed(divider_count_r));
endmodule : lvdc_capture_asserts

// >>> verif/lvdc_capture_tb.sv
// self-checking bench for the ddr sample capture block
// assumes: lvdc_src drives source clock and lanes; sync pin driven by the bench
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; \
   $display("mismatch %0t got %h exp %h", $time, a, e); end end
module lvdc_capture_tb;
   logic clock = 1'b0, rst = 1'b1, cclk = 1'b0, cc_run = 1'b1;
   logic align = 1'b0, gate = 1'b1, rev = 1'b0, sync = 1'b0, sclk, valid, ovf;
   logic [11:0] ena = 12'hfff, word, cur, lanes;
   logic [3:0] cnt;
   logic [2:0] cdiv = 3'h0;
   int errors = 0, n_tests = 0;
   initial forever #2.5 clock = ~clock;
   // converter clock can stand so the fifo fills up first
   always @(posedge clock) if (cc_run) begin
      cdiv <= cdiv + 3'h1;
      if (cdiv == 3'h7) cclk <= ~cclk;
   end
   lvdc_src i_lvdc_src (.clock(clock), .ddr_source_clock(sclk), .lane_data(lanes));
   lvdc_capture i_lvdc_capture (.clock(clock), .rst(rst), .ddr_source_clock(sclk),
      .lane_data(lanes), .fifo_sync_input(sync), .converter_sample_clock(cclk),
      .divider_align_input(align), .transmit_gate(gate), .bus_reverse(rev),
      .lane_enable(ena), .sample_word_r(word), .sample_valid_r(valid),
      .current_output_r(cur), .divider_count_r(cnt), .fifo_overflow_r(ovf));
   // ==========
   // scenarios
   task automatic get(input logic [11:0] e);
      for (int i = 0; i < 100 && valid !== 1'b1; i++) @(negedge clock);
      `CHK(valid, 1'b1)
      `CHK(word, e)
      @(negedge clock);
      `CHK(cur, ~e)
   endtask : get
   task automatic t_pair;
      @(posedge clock) cc_run <= 1'b0;
      i_lvdc_src.send(12'h123, 12'h456);
      i_lvdc_src.send(12'h789, 12'habc);
      cc_run <= 1'b1;
      get(12'h123);
      get(12'h456);
      get(12'h789);
      get(12'habc);
   endtask : t_pair
   task automatic t_rev;
      @(posedge clock) rev <= 1'b1;
      i_lvdc_src.send(12'h001, 12'h0c0);
      get(12'h800);
      get(12'h030);
      @(posedge clock) rev <= 1'b0;
   endtask : t_rev
   task automatic t_lane;
      @(posedge clock) ena <= 12'h0f0;
      i_lvdc_src.send(12'hfff, 12'h123);
      get(12'h0f0);
      get(12'h020);
      @(posedge clock) ena <= 12'hfff;
   endtask : t_lane
   task automatic t_gate;
      @(posedge clock) cc_run <= 1'b0;
      i_lvdc_src.send(12'h5a5, 12'h3c3);
      gate <= 1'b0;
      // second pair arrives while gated, so it must be stored as zeros
      i_lvdc_src.send(12'h6b6, 12'h4d4);
      repeat (8) @(posedge clock);
      cc_run <= 1'b1;
      get(12'h000);
      get(12'h000);
      @(posedge clock) gate <= 1'b1;
      get(12'h000);
      get(12'h000);
   endtask : t_gate
   task automatic t_sync;
      @(posedge clock) cc_run <= 1'b0;
      // one pair more than the fifo holds
      repeat (9) i_lvdc_src.send(12'h100, 12'h200);
      @(negedge clock);
      `CHK(ovf, 1'b1)
      @(posedge clock) sync <= 1'b1;
      i_lvdc_src.send(12'h7e1, 12'h1e7);
      sync <= 1'b0;
      @(negedge clock);
      `CHK(ovf, 1'b0)
      @(posedge clock) cc_run <= 1'b1;
      // cleared pointers: the pair sent with sync comes out first
      get(12'h7e1);
      get(12'h1e7);
   endtask : t_sync
   task automatic t_align;
      @(posedge clock) align <= 1'b1;
      repeat (40) @(posedge clock);
      align <= 1'b0;
      @(negedge clock);
      `CHK(cnt, lvdc_pkg::DIV_RESET)
      repeat (40) @(negedge clock);
      `CHK(cnt != lvdc_pkg::DIV_RESET, 1'b1)
   endtask : t_align
   task automatic summarize;
      $display("errors %0d checks %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize
   initial begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      t_pair;
      t_rev;
      t_lane;
      t_gate;
      t_sync;
      t_align;
      summarize;
   end
   initial begin
      repeat (4000) @(posedge clock);
      errors++;
      summarize;
   end
endmodule : lvdc_capture_tb
bind lvdc_capture lvdc_capture_asserts #(.DATA_W(DATA_W), .DIV_W(DIV_W)) i_lvdc_capture_asserts (
   .clock, .rst, .transmit_gate, .bus_reverse, .lane_enable, .divider_align_input,
   .sample_word_r, .sample_valid_r, .current_output_r, .divider_count_r);

// >>> verif/lvdc_src.sv
// data source model: drives the ddr source clock and the twelve lanes
// assumes: clock far above the source clock; one word pair per send call
`timescale 1ns/1ps
module lvdc_src (
   input wire logic clock,
   output logic ddr_source_clock,
   output logic [11:0] lane_data
);
   initial begin
      ddr_source_clock = 1'b0;
      lane_data = 12'h000;
   end
   // ==========
   // four clocks of set-up and hold around each edge
   task automatic send(input logic [11:0] a, input logic [11:0] b);
      @(posedge clock);
      lane_data <= a;
      repeat (4) @(posedge clock);
      ddr_source_clock <= 1'b1;
      repeat (4) @(posedge clock);
      lane_data <= b;
      repeat (4) @(posedge clock);
      ddr_source_clock <= 1'b0;
      repeat (4) @(posedge clock);
      lane_data <= ~b; // stale lanes must not look like the word
   endtask : send
endmodule : lvdc_src
